// ---- design/epw_cfg.svh ----
`ifndef EPW_CFG_SVH
`define EPW_CFG_SVH

// Clock rate and derived timing (20 MHz, 50 ns period)
`define EPW_CLK_NS          50
`define EPW_PAGE_DWORDS     128
`define EPW_LOAD_CYCLE_US   30
`define EPW_LOAD_CYCLE_CYC  ((`EPW_LOAD_CYCLE_US * 1000) / `EPW_CLK_NS)
`define EPW_AUTO_START_US   100
`define EPW_AUTO_START_CYC  ((`EPW_AUTO_START_US * 1000) / `EPW_CLK_NS)
`define EPW_PROGRAM_CYCLE_MS 15
`define EPW_PROGRAM_CYCLE_CYC ((`EPW_PROGRAM_CYCLE_MS * 1000000) / `EPW_CLK_NS)
`define EPW_RESUME_DELAY_NS 250
`define EPW_RESUME_DELAY_CYC \
	((`EPW_RESUME_DELAY_NS + `EPW_CLK_NS - 1) / `EPW_CLK_NS)
`define EPW_BUSY_ONSET_NS   120
`define EPW_BUSY_ONSET_CYC \
	((`EPW_BUSY_ONSET_NS + `EPW_CLK_NS - 1) / `EPW_CLK_NS)
`define EPW_LOAD_SPACING_NS 750
`define EPW_LOAD_SPACING_CYC \
	((`EPW_LOAD_SPACING_NS + `EPW_CLK_NS - 1) / `EPW_CLK_NS)
`define EPW_GUARD_LEAD_US   100
`define EPW_GUARD_LEAD_CYC  ((`EPW_GUARD_LEAD_US * 1000) / `EPW_CLK_NS)
// Strobe low time in cycles (covers 250 ns pulse width)
`define EPW_STROBE_CYC      6
// Read access wait (covers 250 ns access)
`define EPW_READ_CYC        6
`define EPW_POLL_BIT0       7
`define EPW_TIMER_W         20

`endif

// ---- design/epw_host.sv ----
`timescale 1ns/100ps
`include "epw_cfg.svh"

// Notes on behaviour
// [RULE1] A page load holds one to 128 dwords, programmed in one cycle.
// [RULE2] Host strobes each next dword within 30 us of the last.
// [RULE3] Memory starts programming after 100 us of idle strobes.
// [RULE4] Address latched on strobe fall, data on strobe rise.
// [RULE5] Host keeps page address bits 16..7 fixed within a page load.
// [RULE6] Polled read returns inverted bit 7 of each byte while busy. The memory model inverts all 32 bits of the last load.
// [RULE7] Ready/busy falls after first strobe, rises when write ends.
// [RULE8] Guard low blocks access, floats data, aborts programming.
// [RULE9] Memory finishes each program cycle within the maximum time.
// [RULE10] Maximum program cycle time is 15 ms.
// [RULE11] Without completion sensing, host waits the full cycle time.
// [RULE12] After completion, host waits 250 ns before next access.
// [RULE13] Host waits 120 ns after a write before sampling busy.
// [RULE14] Host spaces data latches in a page at least 750 ns apart.
// [RULE15] Host raises guard at least 100 us before writing.
// [RULE16] Host holds guard low across supply up and down.
// [RULE17] Host enables at most one chip select at a time.
// [RULE18] Memory ignores writes with strobe high or output enable low.
module epw_host (
	input  wire logic             MCLK,
	input  wire logic             RESET_N,
	input  wire logic             POWER_OK,
	input  wire logic             USE_READY,
	input  wire epw_pkg::epw_req_t REQ,
	input  wire logic             REQ_VALID,
	output logic                  REQ_READY,
	output logic [31:0]           RD_DATA,
	output logic                  RD_VALID,
	output logic                  PAGE_ERROR,
	output logic                  BUSY,
	output epw_pkg::epw_pins_t    MEM,
	output logic [31:0]           MEM_DQ_O,
	output logic                  MEM_DQ_OE,
	input  wire logic [31:0]      MEM_DQ_I,
	input  wire logic             MEM_READY,
	output logic                  MEM_GUARD_N
);
	epw_pkg::epw_state_t state;
	epw_pkg::epw_state_t next_state;
	epw_pkg::epw_pins_t  pins;
	logic [31:0]         wdata;
	logic [9:0]          page;
	logic [7:0]          count;
	logic                page_open;
	logic                guard_ok;
	logic                is_write;
	logic                is_last;
	logic                t_load;
	logic [`EPW_TIMER_W-1:0] t_value;
	logic                t_done;
	logic                g_load;
	logic                g_done;
	logic                accept;
	logic                page_clash;
	logic                full_page;
	logic                idle_take;
	logic                gap_take;

	epw_timer u_timer (
		.clk   (MCLK),
		.rst_n (RESET_N),
		.load  (t_load),
		.value (t_value),
		.done  (t_done)
	);

	// Guard lead timer runs from the guard release
	epw_timer u_guard (
		.clk   (MCLK),
		.rst_n (RESET_N),
		.load  (g_load),
		.value (`EPW_TIMER_W'(`EPW_GUARD_LEAD_CYC)),
		.done  (g_done)
	);

	// Request decode
	assign accept     = REQ_VALID && REQ_READY;
	assign page_clash = page_open && REQ.write && (REQ.addr[16:7] != page);
	assign full_page  = (count == 8'(`EPW_PAGE_DWORDS - 1));
	// Ready only when the request really moves on; in ST_GAP a guard drop can still take one and lose it
	// [RULE15] guard lead
	assign idle_take  = guard_ok && (!REQ.write || g_done);
	// [RULE5] other page held; reads wait until the page is written
	assign gap_take   = t_done && REQ.write && !page_clash && !is_last &&
		!full_page;
	assign REQ_READY  = ((state == epw_pkg::ST_IDLE) && idle_take) ||
		((state == epw_pkg::ST_GAP) && gap_take);
	assign BUSY       = (state != epw_pkg::ST_IDLE);

	// [RULE16] guard follows supply; [RULE15] lead timer restarts on drop
	assign g_load = !POWER_OK || !guard_ok;

	// Next state and timer load selection
	always_comb begin
		next_state = state;
		t_load     = 1'b0;
		t_value    = '0;
		case (state)
		epw_pkg::ST_IDLE: begin
			if (accept && !page_clash && guard_ok &&
					(!REQ.write || g_done)) begin
				next_state = epw_pkg::ST_STROBE;
				t_load     = 1'b1;
				t_value    = `EPW_TIMER_W'(`EPW_STROBE_CYC);
			end
		end
		epw_pkg::ST_STROBE: begin
			if (t_done) begin
				t_load  = 1'b1;
				if (is_write) begin
					// [RULE14] latch spacing
					next_state = epw_pkg::ST_GAP;
					t_value    = `EPW_TIMER_W'(`EPW_LOAD_SPACING_CYC -
						`EPW_STROBE_CYC);
				end else begin
					next_state = epw_pkg::ST_READ;
					t_value    = `EPW_TIMER_W'(1);
				end
			end
		end
		epw_pkg::ST_GAP: begin
			if (accept && !page_clash) begin
				next_state = epw_pkg::ST_STROBE;
				t_load     = 1'b1;
				t_value    = `EPW_TIMER_W'(`EPW_STROBE_CYC);
			end else if (t_done) begin
				// [RULE2] close load; [RULE3] idle strobes start programming
				next_state = epw_pkg::ST_SETTLE;
				t_load     = 1'b1;
				t_value    = `EPW_TIMER_W'(`EPW_AUTO_START_CYC +
					`EPW_BUSY_ONSET_CYC);
			end
		end
		epw_pkg::ST_SETTLE: begin
			if (t_done) begin
				next_state = epw_pkg::ST_WAIT;
				t_load     = 1'b1;
				// [RULE11] fixed wait; [RULE10] 15 ms
				t_value    = `EPW_TIMER_W'(`EPW_PROGRAM_CYCLE_CYC);
			end
		end
		epw_pkg::ST_WAIT: begin
			// [RULE7] ready sense; [RULE13] sampled after onset delay
			if (t_done || (USE_READY && MEM_READY)) begin
				next_state = epw_pkg::ST_RESUME;
				t_load     = 1'b1;
				// [RULE12] resume delay
				t_value    = `EPW_TIMER_W'(`EPW_RESUME_DELAY_CYC);
			end
		end
		epw_pkg::ST_RESUME: begin
			if (t_done)
				next_state = epw_pkg::ST_IDLE;
		end
		epw_pkg::ST_READ: begin
			if (t_done)
				next_state = epw_pkg::ST_IDLE;
		end
		default: next_state = epw_pkg::ST_IDLE;
		endcase
		// [RULE8] guard drop aborts any access in flight
		if (!guard_ok)
			next_state = epw_pkg::ST_IDLE;
	end

	// Pin drive; strobe low in ST_STROBE for writes, only one select active
	always_comb begin
		pins             = MEM;
		pins.wr_strobe_n = 1'b1;
		pins.out_en_n    = 1'b1;
		pins.chip_sel_n  = 2'b11;
		if (next_state == epw_pkg::ST_STROBE) begin
			// [RULE17] single chip select
			pins.chip_sel_n = REQ.bank ? 2'b01 : 2'b10;
			if (state != epw_pkg::ST_STROBE) begin
				pins.addr = REQ.addr;
				// [RULE18] output enable held high on writes
				pins.out_en_n = REQ.write;
			end else begin
				pins.chip_sel_n = MEM.chip_sel_n;
				pins.out_en_n   = MEM.out_en_n;
			end
			// Stale is_write must not strobe a read that follows a write
			pins.wr_strobe_n = (state == epw_pkg::ST_STROBE) ? !is_write :
				!REQ.write;
		end else if (next_state == epw_pkg::ST_READ) begin
			pins.chip_sel_n = MEM.chip_sel_n;
			pins.out_en_n   = 1'b0;
		end
	end

	// Pins and data registered so the memory sees clean edges
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			state       <= epw_pkg::ST_IDLE;
			MEM         <= '{chip_sel_n: 2'b11, out_en_n: 1'b1,
				wr_strobe_n: 1'b1, addr: 17'h00000};
			MEM_GUARD_N <= 1'b0;
			guard_ok    <= 1'b0;
		end else begin
			state       <= next_state;
			// [RULE4] address registered on the same edge as the strobe fall
			MEM         <= pins;
			MEM_GUARD_N <= POWER_OK;
			guard_ok    <= POWER_OK;
		end
	end

	// Page bookkeeping and write data hold past the strobe rise
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			wdata     <= 32'h00000000;
			page      <= 10'h000;
			count     <= 8'h00;
			page_open <= 1'b0;
			is_write  <= 1'b0;
			is_last   <= 1'b0;
		end else if (accept && next_state == epw_pkg::ST_STROBE) begin
			wdata    <= REQ.data;
			is_write <= REQ.write;
			is_last  <= REQ.last;
			if (REQ.write) begin
				// [RULE5] page held; [RULE1] dword count
				page      <= REQ.addr[16:7];
				count     <= page_open ? count + 8'h01 : 8'h00;
				page_open <= 1'b1;
			end
		end else if (next_state == epw_pkg::ST_IDLE) begin
			page_open <= 1'b0;
			count     <= 8'h00;
		end
	end

	// Data drive: output enable only for write strobes, guard permitting
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			MEM_DQ_O  <= 32'h00000000;
			MEM_DQ_OE <= 1'b0;
		end else begin
			MEM_DQ_O  <= accept ? REQ.data : wdata;
			// Held one cycle past the strobe rise for data hold
			MEM_DQ_OE <= (state == epw_pkg::ST_STROBE) ? is_write :
				((next_state == epw_pkg::ST_STROBE) && REQ.write);
		end
	end

	// Read return taken in the last cycle of the access
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			RD_DATA    <= 32'h00000000;
			RD_VALID   <= 1'b0;
			PAGE_ERROR <= 1'b0;
		end else begin
			RD_VALID   <= (state == epw_pkg::ST_READ) && t_done;
			PAGE_ERROR <= REQ_VALID && page_clash;
			if ((state == epw_pkg::ST_READ) && t_done)
				RD_DATA <= MEM_DQ_I;
		end
	end
endmodule // epw_host

// ---- design/epw_pkg.sv ----
package epw_pkg;

	typedef enum logic [7:0] {
		ST_IDLE   = 8'h01,
		ST_LEAD   = 8'h02,
		ST_STROBE = 8'h04,
		ST_GAP    = 8'h08,
		ST_SETTLE = 8'h10,
		ST_WAIT   = 8'h20,
		ST_RESUME = 8'h40,
		ST_READ   = 8'h80
	} epw_state_t;

	// Host request from the user side
	typedef struct packed {
		logic        write;
		logic        last;
		logic        bank;
		logic [16:0] addr;
		logic [31:0] data;
	} epw_req_t;

	// Memory pin bundle driven by the host
	typedef struct packed {
		logic [1:0]  chip_sel_n;
		logic        out_en_n;
		logic        wr_strobe_n;
		logic [16:0] addr;
	} epw_pins_t;

endpackage

// ---- design/epw_timer.sv ----
`timescale 1ns/100ps
`include "epw_cfg.svh"

// Down counter; done is high once the loaded count has run out
module epw_timer (
	input  wire logic                   clk,
	input  wire logic                   rst_n,
	input  wire logic                   load,
	input  wire logic [`EPW_TIMER_W-1:0] value,
	output logic                        done
);
	logic [`EPW_TIMER_W-1:0] count;

	assign done = (count == '0);

	// Reload wins over counting
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			count <= '0;
		else if (load)
			count <= value;
		else if (!done)
			count <= count - 1'b1;
	end
endmodule // epw_timer

// ---- sim/epw_host_assertions.sv ----
`timescale 1ns/100ps
// Watches the host pins for the timing the memory relies on
module epw_host_assertions (
	input wire logic               MCLK,
	input wire logic               RESET_N,
	input wire logic               POWER_OK,
	input wire logic               BUSY,
	input wire logic               RD_VALID,
	input wire epw_pkg::epw_pins_t MEM,
	input wire logic               MEM_READY,
	input wire logic               MEM_GUARD_N
);
	logic        we_q;
	logic [11:0] gcnt, fcnt, rcnt;
	logic [9:0]  pg;
	wire         fall = we_q & ~MEM.wr_strobe_n;
	wire         rise = ~we_q & MEM.wr_strobe_n;

	// Saturating ages, so long idles never wrap into short ones
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			we_q <= 1'b1;
			gcnt <= 12'h000;
			fcnt <= 12'hFFF;
			rcnt <= 12'hFFF;
			pg <= 10'h000;
		end else begin
			we_q <= MEM.wr_strobe_n;
			gcnt <= !MEM_GUARD_N ? 12'h000 : gcnt + {11'h0, gcnt != 12'hFFF};
			fcnt <= fall ? 12'h000 : fcnt + {11'h0, fcnt != 12'hFFF};
			rcnt <= rise ? 12'h000 : rcnt + {11'h0, rcnt != 12'hFFF};
			if (fall)
				pg <= MEM.addr[16:7];
		end
	end

	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RESET_N);

	one_select_a: assert property (MEM.chip_sel_n != 2'h0)
		else $error("both chip selects low");
	guard_follow_a: assert property (!POWER_OK |=> !MEM_GUARD_N)
		else $error("guard high without supply");
	guard_lead_a: assert property (fall |-> gcnt >= 12'h7D0)
		else $error("write too soon after guard rise");
	page_fixed_a: assert property (fall && fcnt < 12'h258 |->
		MEM.addr[16:7] == pg) else $error("page changed in load");
	load_window_a: assert property (fall |->
		fcnt < 12'h258 || fcnt >= 12'h7D0) else $error("late dword");
	latch_space_a: assert property (rise |-> rcnt >= 12'h00E)
		else $error("data latches too close");
	resume_gap_a: assert property ($rose(MEM_READY) |->
		(MEM.chip_sel_n == 2'h3) [*5]) else $error("resumed too early");
	busy_hold_a: assert property (MEM_GUARD_N && POWER_OK &&
		!MEM_READY |-> BUSY) else $error("host idle while memory busy");

	cover property (fall);
	cover property ($rose(MEM_READY));
	cover property (RD_VALID);
endmodule // epw_host_assertions

// ---- sim/epw_mem_model.sv ----
`timescale 1ns/100ps
// Page-write memory: buffers a page, programs after idle strobes
module epw_mem_model #(
	parameter int PROG_NS = 50000
) (
	input  wire epw_pkg::epw_pins_t pins,
	input  wire logic               guard_n,
	input  wire logic [31:0]        dq,
	output logic [31:0]             dq_out,
	output logic                    ready
);
	logic [31:0] mem [int];
	logic [31:0] page [int];
	logic [31:0] last;
	logic [16:0] alat;
	logic        busy, prog;
	realtime     t_last;
	wire         sel = pins.chip_sel_n != 2'h3;
	wire         rd = guard_n && sel && !pins.out_en_n && pins.wr_strobe_n;
	// Strobe qualified by select, so either pin can open or end a cycle
	wire         wr_act = guard_n && pins.chip_sel_n != 2'h3 &&
		!pins.wr_strobe_n && pins.out_en_n;

	// Inverted poll data; released lines
	// show the inverse of the last load, never a held value
	always @* dq_out = (rd && !prog) ? mem[pins.addr] : ~last;
	// Busy from first strobe, ready under guard
	assign ready = !busy || !guard_n;
	// Address as the write opens, blocked by output enable
	always @(posedge wr_act)
		if (!prog) begin
			alat = pins.addr;
			busy = 1'b1;
		end
	// Data as the write closes, into page buffer
	always @(negedge wr_act)
		if (guard_n && busy && !prog) begin
			page[alat] = dq;
			last = dq;
			t_last = $realtime;
		end
	// Program after idle, abort on guard
	initial begin
		busy = 1'b0;
		prog = 1'b0;
		last = 32'h0;
		forever begin
			#1000;
			if (busy && !sel && pins.wr_strobe_n &&
					$realtime - t_last >= 100000) begin
				prog = 1'b1;
				fork
					#PROG_NS;
					wait (!guard_n);
				join_any
				disable fork;
				if (guard_n)
					foreach (page[a])
						mem[a] = page[a];
			end
			if (prog || !guard_n) begin
				page.delete();
				busy = 1'b0;
				prog = 1'b0;
			end
		end
	end
endmodule // epw_mem_model

// ---- sim/tb.sv ----
`timescale 1ns/100ps
module tb;
	logic               mclk, reset_n, power_ok, req_valid, req_ready;
	logic               rd_valid, page_error, busy, dq_oe, mem_ready;
	logic               guard_n, perr_seen, use_ready;
	logic [31:0]        rd_data, dq_o, dq_mem;
	epw_pkg::epw_req_t  req;
	epw_pkg::epw_pins_t mem;
	wire  [31:0]        dq = dq_oe ? dq_o : dq_mem;
	int                 fail_count, tests_run;

	epw_host epw_host_inst (.MCLK(mclk), .RESET_N(reset_n),
		.POWER_OK(power_ok), .USE_READY(use_ready), .REQ(req),
		.REQ_VALID(req_valid), .REQ_READY(req_ready), .RD_DATA(rd_data),
		.RD_VALID(rd_valid), .PAGE_ERROR(page_error), .BUSY(busy),
		.MEM(mem), .MEM_DQ_O(dq_o), .MEM_DQ_OE(dq_oe), .MEM_DQ_I(dq),
		.MEM_READY(mem_ready), .MEM_GUARD_N(guard_n));
	epw_mem_model epw_mem_model_inst (.pins(mem), .guard_n(guard_n),
		.dq(dq), .dq_out(dq_mem), .ready(mem_ready));

	// 20 MHz clock
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	// Cut a hang short, traffic needs about 1 ms
	initial begin
		#4000000;
		fail_count++;
		stop_test();
	end
	// Clash flag drops once the open page closes, before the check, so latch it
	always @(posedge mclk)
		if (page_error === 1'b1)
			perr_seen <= 1'b1;

	task automatic check(input string name, input logic [31:0] exp, got);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("FAIL %s expected %h seen %h", name, exp, got);
		end
	endtask
	// Offer one request and hold it until taken
	task automatic put(input logic w, l, input logic [16:0] a,
			input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		req <= '{write: w, last: l, bank: a[16], addr: a, data: d};
		req_valid <= 1'b1;
		do begin
			@(posedge mclk);
			n++;
		end while (req_ready !== 1'b1 && n < 20000);
		req_valid <= 1'b0;
		check("request taken", 32'h1, {31'h0, req_ready});
	endtask
	task automatic get(input logic [16:0] a, input logic [31:0] exp);
		int n;
		put(1'b0, 1'b0, a, 32'h0);
		n = 0;
		while (rd_valid !== 1'b1 && n < 50) begin
			@(posedge mclk);
			n++;
		end
		check("read valid", 32'h1, {31'h0, rd_valid});
		check("read data", exp, rd_data);
	endtask
	task automatic idle(input int lim);
		int n;
		n = 0;
		@(posedge mclk);
		while (busy !== 1'b0 && n < lim) begin
			@(posedge mclk);
			n++;
		end
		check("host idle", 32'h0, {31'h0, busy});
	endtask
	// Guard stays low until the supply is good
	task automatic t_power;
		check("selects idle", 32'h3, {30'h0, mem.chip_sel_n});
		check("guard low", 32'h0, {31'h0, guard_n});
		power_ok <= 1'b1;
		repeat (2) @(posedge mclk);
		check("guard high", 32'h1, {31'h0, guard_n});
	endtask
	// Full 128-dword page, one program cycle
	task automatic t_page;
		for (int i = 0; i < 128; i++)
			put(1'b1, i == 127, {10'h003, i[6:0]}, {4{i[7:0]}} ^ 32'h5A5A0000);
		check("ready busy low", 32'h0, {31'h0, mem_ready});
		idle(20000);
		check("ready busy high", 32'h1, {31'h0, mem_ready});
		get(17'h00180, 32'h5A5A0000);
		get(17'h001FF, 32'h25257F7F);
	endtask
	// Other page held until the open one has been programmed
	task automatic t_clash;
		put(1'b1, 1'b0, 17'h10405, 32'hC3C30001);
		put(1'b1, 1'b1, 17'h10805, 32'h3C3C0002);
		check("clash flagged", 32'h1, {31'h0, perr_seen});
		idle(20000);
		get(17'h10405, 32'hC3C30001);
		get(17'h10805, 32'h3C3C0002);
	endtask
	// Supply loss mid-programming keeps the old data
	task automatic t_abort;
		put(1'b1, 1'b1, 17'h00180, 32'hDEAD0000);
		repeat (2100) @(posedge mclk);
		power_ok <= 1'b0;
		repeat (4) @(posedge mclk);
		check("abort idle", 32'h0, {31'h0, busy});
		check("guard ready", 32'h1, {31'h0, mem_ready});
		check("abort selects", 32'h3, {30'h0, mem.chip_sel_n});
		power_ok <= 1'b1;
		repeat (3) @(posedge mclk);
		get(17'h00180, 32'h5A5A0000);
	endtask
	// Fixed program wait outlasts ready; guard drop ends it early
	task automatic t_fixed;
		use_ready <= 1'b0;
		put(1'b1, 1'b1, 17'h00181, 32'h0F0F1234);
		repeat (3200) @(posedge mclk);
		check("ready high", 32'h1, {31'h0, mem_ready});
		check("fixed wait busy", 32'h1, {31'h0, busy});
		power_ok <= 1'b0;
		repeat (4) @(posedge mclk);
		check("wait cut", 32'h0, {31'h0, busy});
		power_ok <= 1'b1;
		use_ready <= 1'b1;
		repeat (3) @(posedge mclk);
		get(17'h00181, 32'h0F0F1234);
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial begin
		reset_n = 1'b0;
		power_ok = 1'b0;
		req = '0;
		req_valid = 1'b0;
		perr_seen = 1'b0;
		use_ready = 1'b1;
		fail_count = 0;
		tests_run = 0;
		repeat (5) @(posedge mclk);
		reset_n <= 1'b1;
		@(posedge mclk);
		t_power();
		t_page();
		t_clash();
		t_abort();
		t_fixed();
		stop_test();
	end
endmodule // tb

bind epw_host epw_host_assertions epw_host_assertions_inst (.MCLK(MCLK),
	.RESET_N(RESET_N), .POWER_OK(POWER_OK), .BUSY(BUSY),
	.RD_VALID(RD_VALID), .MEM(MEM), .MEM_READY(MEM_READY),
	.MEM_GUARD_N(MEM_GUARD_N));
